// >>> ctrl_dev_defs.svh
// offsets, field positions, reset values and counts for the control device
`ifndef CTRL_DEV_DEFS_SVH
`define CTRL_DEV_DEFS_SVH
`define OFS_JOY_PWR      3'h0
`define OFS_EEPROM       3'h1
`define OFS_BLOCK_PD     3'h2
`define OFS_IND_INDEX    3'h3
`define OFS_IND_DATA     3'h4
`define OFS_RAM_CMD      3'h5
`define OFS_RAM_END      3'h6
`define OFS_GLOBAL_STAT  3'h7
`define RST_JOY_PWR      8'h00
`define RST_EEPROM       8'h80
`define RST_BLOCK_PD     8'h00
`define RST_IND_INDEX    4'h0
`define IND_LAST         4'h8
`define IND_COUNT        9
// joystick/power control fields
`define JP_SPEED_LO      0
`define JP_MIXER_PD      2
`define JP_BLOCK_IDLE_A_PD       3
`define JP_CONV_PD       4
`define JP_CTX_EN        5
`define JP_CODE_LO       6
// eeprom port fields
`define EE_CLK           0
`define EE_DOUT          1
`define EE_DIN_EN        2
`define EE_LOOP_LO       3
`define EE_MODEM_POL     5
`define EE_SYNTH_POL     6
`define EE_CDROM_POL     7
// block power-down fields
`define BP_FM            0
`define BP_BLOCK_IDLE_A          1
`define BP_DAC           2
`define BP_ADC           3
`define BP_MIX           4
`define BP_VREF          5
`define BP_SRC           6
`define BP_GLOBAL        7
`endif

// >>> ctrl_dev_pkg.sv
// types shared by the control device
`default_nettype none
package ctrl_dev_pkg;
  typedef enum logic [1:0] {
    pm_active, pm_conv_off, pm_full_off, pm_iface_off
  } legacy_pm_t;
  typedef enum logic [1:0] {
    loop_normal, loop_rec_mux, loop_rec_out, loop_reserved
  } loop_sel_t;
  typedef enum logic [1:0] {ram_command, ram_download} ram_mode_t;
endpackage
`default_nettype wire

// >>> control_device_register_bank.sv
// control logical device register bank on the host i/o bus
`default_nettype none
`include "ctrl_dev_defs.svh"

module control_device_register_bank (
  input  wire logic        clk,             // 10 MHz system clock
  input  wire logic        srst,            // synchronous reset, high
  // host i/o bus
  input  wire logic [15:0] host_addr,       // full i/o address
  input  wire logic [11:0] control_io_base, // assigned base
  input  wire logic        io_rd,           // read strobe, one cycle
  input  wire logic        io_wr,           // write strobe, one cycle
  input  wire logic [7:0]  io_wdata,        // write data
  output logic      [7:0]  io_rdata,        // read data
  output logic             io_hit,          // address decoded
  // hardware configuration preset of polarity bits
  input  wire logic        cfg_load,        // preset strobe
  input  wire logic [2:0]  cfg_polarity,    // cdrom, synth, modem
  // indirect register file, held elsewhere
  output logic      [3:0]  indirect_index_bits, // selected index
  output logic      [7:0]  indirect_data_bits,  // write data
  output logic             ind_wr,          // indirect write pulse
  output logic             ind_rd,          // indirect read pulse
  input  wire logic [7:0]  ind_rdata,       // indirect read value
  // ram port and global status, outside this bank
  output logic             ram_cmd_wr,      // offset 5 write pulse
  output logic             ram_cmd_rd,      // offset 5 read pulse
  input  wire logic [7:0]  ram_rdata,       // offset 5 read value
  output logic             ram_download_mode, // download active
  input  wire logic        ram_download_start, // download begun
  input  wire logic [7:0]  global_status_in,  // other status bits
  // eeprom serial port
  output logic             eeprom_clk_o,    // clock pin value
  output logic             eeprom_clk_oe,   // clock pin enable
  output logic             eeprom_dout_o,   // data pin value
  output logic             eeprom_dout_oe,  // data pin enable
  input  wire logic        periph_data_pin0, // eeprom serial output
  // peripheral interrupt pins
  input  wire logic        modem_irq_pin,   // raw modem request
  input  wire logic        synth_irq_pin,   // raw synth request
  input  wire logic        cdrom_irq_pin,   // raw cdrom request
  output logic             modem_irq,       // normalised, high
  output logic             synth_irq,       // normalised, high
  output logic             cdrom_irq,       // normalised, high
  // context switch
  input  wire logic        ctx_switch,      // mode change pulse
  input  wire logic        ctx_is_native,   // current context
  output logic             ctx_irq,         // host interrupt
  output logic             ctx_switch_irq_status, // pending flag
  input  wire logic        ctx_irq_ack,     // clears pending
  // processor interface activity
  input  wire logic        iface_access,    // pnp/midi/emu access
  // power and mode controls
  output logic      [1:0]  joystick_speed_sel, // timer threshold
  output logic             mixer_pd_eff,    // analog mixer off
  output logic             mixer_regs_reset, // codec mixer defaults
  output logic             processor_idle,  // processor idled
  output logic             ifaces_pd,       // linked ifaces down
  output logic             adc_pd,          // a/d converters off
  output logic             dac_pd,          // d/a and serial off
  output logic             fm_pd,           // internal synth off
  output logic             vref_pd,         // whole analog off
  output logic             rate_converter_pd, // 44.1 kHz only
  output logic             volume_freeze,   // volume regs frozen
  output logic             mono_bypass,     // forced bypass
  output logic             chip_reset,      // full-part reset
  output logic             chip_pd,         // global power-down
  output logic             calibrate,       // calibration pulse
  output logic      [1:0]  loopback_mux_sel // mixing path
);

  // ***************************************************************
  // register state
  // ***************************************************************
  logic [7:0] joy_pwr;        // offset 0
  logic [7:0] eeprom_port;    // offset 1, bit 2 holds enable
  logic [7:0] block_pd;       // offset 2
  logic [3:0] index_q;        // offset 3 low nibble
  logic       ifaces_down;    // linked interfaces powered off
  logic       block_idle_a_idle_q;    // processor idle state
  logic       ctx_pend;       // context switch pending
  ctrl_dev_pkg::ram_mode_t ram_mode; // offset 5 mode
  logic [2:0] din_sync;       // eeprom data synchroniser
  logic       din_level;      // filtered eeprom data
  logic [2:0] modem_sync;     // modem pin synchroniser
  logic [2:0] synth_sync;     // synth pin synchroniser
  logic [2:0] cdrom_sync;     // cdrom pin synchroniser
  logic       modem_lvl;      // filtered modem pin
  logic       synth_lvl;      // filtered synth pin
  logic       cdrom_lvl;      // filtered cdrom pin

  // ***************************************************************
  // address decode
  // ***************************************************************
  logic       in_window;      // address inside eight locations
  logic [2:0] offset;         // location within the block
  logic [11:0] addr_diff;     // low address minus base
  logic       code_full_off;  // legacy code 10 active
  logic       wr_en;          // write allowed now
  logic       rd_en;          // read allowed now
  logic       acc_ok;         // offset reachable in this state

  // decode the offset from twelve bits against the base
  always_comb begin
    addr_diff = host_addr[11:0] - control_io_base;
    offset    = addr_diff[2:0];
    in_window = (addr_diff[11:3] == 9'h000) &&
                (host_addr[15:12] == 4'h0);
  end

  // code 10 locks out all offsets but 0; global power-down keeps 2
  assign code_full_off = (joy_pwr[`JP_CODE_LO +: 2] ==
                          ctrl_dev_pkg::pm_full_off);
  always_comb begin
    if (code_full_off) begin
      acc_ok = (offset == `OFS_JOY_PWR);
    end else if (block_pd[`BP_GLOBAL]) begin
      acc_ok = (offset == `OFS_BLOCK_PD);
    end else begin
      acc_ok = 1'b1;
    end
  end
  assign io_hit = in_window && acc_ok;
  assign wr_en  = io_wr && io_hit;
  assign rd_en  = io_rd && io_hit;

  // per-offset write strobe, decoded in several places
  function automatic logic wr_at(input logic [2:0] ofs);
    wr_at = wr_en && (offset == ofs);
  endfunction

  // ***************************************************************
  // offset 0: joystick and power control
  // ***************************************************************
  // written value is kept and read back unchanged
  always_ff @(posedge clk) begin
    if (srst) begin
      joy_pwr <= `RST_JOY_PWR;
    end else if (wr_at(`OFS_JOY_PWR)) begin
      joy_pwr <= io_wdata;
    end
  end

  // ***************************************************************
  // offset 1: eeprom port, loopback and polarities
  // ***************************************************************
  // code 10 also clears this configuration to its reset value
  always_ff @(posedge clk) begin
    if (srst || code_full_off) begin
      eeprom_port <= `RST_EEPROM;
    end else if (wr_at(`OFS_EEPROM)) begin
      eeprom_port <= io_wdata;
    end else if (cfg_load) begin
      // hardware configuration presets only the polarity bits
      eeprom_port[`EE_CDROM_POL:`EE_MODEM_POL] <= cfg_polarity;
    end
  end

  // pins driven only while the enable bit is one
  assign eeprom_clk_oe  = eeprom_port[`EE_DIN_EN];
  assign eeprom_dout_oe = eeprom_port[`EE_DIN_EN];
  assign eeprom_clk_o   = eeprom_port[`EE_CLK];
  assign eeprom_dout_o  = eeprom_port[`EE_DOUT];
  assign loopback_mux_sel = eeprom_port[`EE_LOOP_LO +: 2];

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      din_sync   <= 3'h0;
      modem_sync <= 3'h0;
      synth_sync <= 3'h0;
      cdrom_sync <= 3'h0;
    end else begin
      din_sync   <= {din_sync[1:0], periph_data_pin0};
      modem_sync <= {modem_sync[1:0], modem_irq_pin};
      synth_sync <= {synth_sync[1:0], synth_irq_pin};
      cdrom_sync <= {cdrom_sync[1:0], cdrom_irq_pin};
    end
  end

  // filtered levels move only on agreement of the last two stages
  always_ff @(posedge clk) begin
    if (srst) begin
      din_level <= 1'b0;
      modem_lvl <= 1'b0;
      synth_lvl <= 1'b0;
      cdrom_lvl <= 1'b0;
    end else begin
      if (din_sync[2] == din_sync[1]) din_level <= din_sync[2];
      if (modem_sync[2] == modem_sync[1]) modem_lvl <= modem_sync[2];
      if (synth_sync[2] == synth_sync[1]) synth_lvl <= synth_sync[2];
      if (cdrom_sync[2] == cdrom_sync[1]) cdrom_lvl <= cdrom_sync[2];
    end
  end

  // polarity bit set means pin active high, clear means active low
  always_ff @(posedge clk) begin
    if (srst) begin
      modem_irq <= 1'b0;
      synth_irq <= 1'b0;
      cdrom_irq <= 1'b0;
    end else begin
      modem_irq <= ~(modem_lvl ^ eeprom_port[`EE_MODEM_POL]);
      synth_irq <= ~(synth_lvl ^ eeprom_port[`EE_SYNTH_POL]);
      cdrom_irq <= ~(cdrom_lvl ^ eeprom_port[`EE_CDROM_POL]);
    end
  end

  // ***************************************************************
  // offset 2: block power-down
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (srst || code_full_off) begin
      block_pd <= `RST_BLOCK_PD;
    end else if (wr_at(`OFS_BLOCK_PD)) begin
      block_pd <= io_wdata;
    end
  end

  // one-cycle calibration pulse when global power-down is cleared
  always_ff @(posedge clk) begin
    if (srst) begin
      calibrate <= 1'b0;
    end else begin
      calibrate <= wr_at(`OFS_BLOCK_PD) && block_pd[`BP_GLOBAL] &&
                   !io_wdata[`BP_GLOBAL];
    end
  end

  // ***************************************************************
  // linked interfaces and processor idle
  // ***************************************************************
  // a set request wins over a same-cycle wake; that access is
  // dropped, and only a later access or code 10 clears the powered-down state
  logic pd_request;   // a write that powers the interfaces down
  logic idle_request; // a write that idles the processor
  always_comb begin
    pd_request = (wr_at(`OFS_JOY_PWR) &&
                  (io_wdata[`JP_BLOCK_IDLE_A_PD] ||
                   io_wdata[`JP_CODE_LO +: 2] ==
                   ctrl_dev_pkg::pm_iface_off));
    idle_request = pd_request ||
                   (wr_at(`OFS_BLOCK_PD) &&
                    (io_wdata[`BP_BLOCK_IDLE_A] || io_wdata[`BP_GLOBAL]));
  end

  always_ff @(posedge clk) begin
    if (srst || code_full_off) begin
      ifaces_down <= 1'b0;
      block_idle_a_idle_q <= 1'b0;
    end else begin
      if (pd_request) begin
        ifaces_down <= 1'b1;
      end else if (iface_access) begin
        ifaces_down <= 1'b0;
      end
      if (idle_request) begin
        block_idle_a_idle_q <= 1'b1;
      end else if (iface_access) begin
        block_idle_a_idle_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // power outputs
  // ***************************************************************
  // code 01 overrides the codec and mixer power-down bits
  always_comb begin
    logic [1:0] code;
    code = joy_pwr[`JP_CODE_LO +: 2];
    joystick_speed_sel = joy_pwr[`JP_SPEED_LO +: 2];
    volume_freeze = (code == ctrl_dev_pkg::pm_conv_off);
    chip_reset    = code_full_off;
    chip_pd       = block_pd[`BP_GLOBAL] || code_full_off;
    vref_pd       = block_pd[`BP_VREF] || chip_pd;
    rate_converter_pd = block_pd[`BP_SRC] || chip_pd;
    mixer_pd_eff  = chip_pd || vref_pd || block_pd[`BP_MIX] ||
                    (code == ctrl_dev_pkg::pm_iface_off) ||
                    (joy_pwr[`JP_MIXER_PD] && !volume_freeze);
    mixer_regs_reset = joy_pwr[`JP_MIXER_PD] && !volume_freeze;
    adc_pd = chip_pd || block_pd[`BP_ADC] || (code != 2'b00) ||
             (joy_pwr[`JP_CONV_PD] && !volume_freeze);
    dac_pd = chip_pd || block_pd[`BP_DAC] || (code != 2'b00) ||
             (joy_pwr[`JP_CONV_PD] && !volume_freeze);
    fm_pd  = block_pd[`BP_FM] || dac_pd;
    ifaces_pd      = ifaces_down || chip_pd;
    processor_idle = block_idle_a_idle_q || ifaces_down || chip_pd;
    // mixer off with reference alive keeps the mono path bypassed
    mono_bypass = block_pd[`BP_MIX] && !block_pd[`BP_VREF];
  end

  // ***************************************************************
  // offsets 3 and 4: indirect access
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (srst || code_full_off) begin
      index_q <= `RST_IND_INDEX;
    end else if (wr_at(`OFS_IND_INDEX)) begin
      index_q <= io_wdata[3:0];
    end
  end
  assign indirect_index_bits = index_q;

  // pulses reach the indirect file only for indices 0 to 8
  always_comb begin
    ind_wr = wr_at(`OFS_IND_DATA) && (index_q <= `IND_LAST);
    ind_rd = rd_en && (offset == `OFS_IND_DATA) &&
             (index_q <= `IND_LAST);
    indirect_data_bits = io_wdata;
  end

  // ***************************************************************
  // offsets 5 and 6: ram port mode
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (srst || code_full_off) begin
      ram_mode <= ctrl_dev_pkg::ram_command;
    end else if (ram_download_start) begin
      ram_mode <= ctrl_dev_pkg::ram_download;
    end else if (wr_at(`OFS_RAM_END) && io_wdata == 8'h00) begin
      ram_mode <= ctrl_dev_pkg::ram_command;
    end
  end
  assign ram_download_mode = (ram_mode == ctrl_dev_pkg::ram_download);
  assign ram_cmd_wr = wr_at(`OFS_RAM_CMD);
  assign ram_cmd_rd = rd_en && (offset == `OFS_RAM_CMD);

  // ***************************************************************
  // context-switch interrupt
  // ***************************************************************
  // a new switch in the acknowledge cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (srst || code_full_off) begin
      ctx_pend <= 1'b0;
    end else if (ctx_switch && joy_pwr[`JP_CTX_EN]) begin
      ctx_pend <= 1'b1;
    end else if (ctx_irq_ack) begin
      ctx_pend <= 1'b0;
    end
  end
  assign ctx_switch_irq_status = ctx_pend;
  assign ctx_irq = ctx_pend && joy_pwr[`JP_CTX_EN];

  // ***************************************************************
  // read data
  // ***************************************************************
  // registered read data, returned the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      io_rdata <= 8'h00;
    end else if (rd_en) begin
      unique case (offset)
        `OFS_JOY_PWR:  io_rdata <= joy_pwr;
        `OFS_EEPROM:   io_rdata <= {eeprom_port[7:3], din_level,
                                    eeprom_port[1:0]};
        `OFS_BLOCK_PD: io_rdata <= block_pd;
        `OFS_IND_INDEX: io_rdata <= {4'h0, index_q};
        `OFS_IND_DATA: io_rdata <= ind_rdata;
        `OFS_RAM_CMD:  io_rdata <= ram_rdata;
        `OFS_RAM_END:  io_rdata <= 8'h00;
        `OFS_GLOBAL_STAT: io_rdata <= {ctx_is_native, ctx_pend,
                                       global_status_in[5:0]};
      endcase
    end
  end

endmodule // control_device_register_bank
`default_nettype wire

// >>> ctrl_bank_monitor.sv
// concurrent checks on the control device register bank ports
`default_nettype none
module ctrl_bank_monitor (
  input wire logic        clk,                   // system clock
  input wire logic        srst,                  // sync reset, high
  input wire logic [15:0] host_addr,             // host i/o address
  input wire logic [11:0] control_io_base,       // assigned base
  input wire logic        io_rd,                 // read strobe
  input wire logic        io_wr,                 // write strobe
  input wire logic [7:0]  io_wdata,              // write data
  input wire logic [7:0]  io_rdata,              // read data
  input wire logic        io_hit,                // decode result
  input wire logic [3:0]  indirect_index_bits,   // indirect index
  input wire logic        ind_wr,                // indirect write
  input wire logic        ind_rd,                // indirect read
  input wire logic        eeprom_clk_oe,         // eeprom enable
  input wire logic        ctx_irq,               // host interrupt
  input wire logic        ctx_switch_irq_status, // pending flag
  input wire logic [1:0]  joystick_speed_sel,    // speed code
  input wire logic        chip_pd,               // global power-down
  input wire logic        chip_reset             // full-part reset
);
  // ****************************************************************
  // offset decode and write sequences
  // ****************************************************************
  wire logic [11:0] rel = host_addr[11:0] - control_io_base; // offset
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wr0;
    io_wr && io_hit && rel == 12'h000;
  endsequence
  sequence s_wr1;
    io_wr && io_hit && rel == 12'h001;
  endsequence
  a_upper_bits_zero: assert property (io_hit |-> host_addr[15:12] == 4'h0)
    else $error("hit with upper address bits set");
  a_window_eight: assert property (io_hit |-> rel < 12'h008)
    else $error("hit outside the eight locations");
  a_speed_follows: assert property (s_wr0 |=> joystick_speed_sel == $past(io_wdata[1:0]))
    else $error("speed code not taken from write");
  a_enable_write: assert property (s_wr1 |=> eeprom_clk_oe == $past(io_wdata[2]))
    else $error("eeprom enable not taken from write");
  a_gpd_lock: assert property (chip_pd && !chip_reset && io_hit |-> rel == 12'h002)
    else $error("access other than offset 2 in power-down");
  a_code_lock: assert property (chip_reset && io_hit |-> rel == 12'h000)
    else $error("access other than offset 0 in full power-down");
  a_index_range: assert property (ind_wr || ind_rd |-> io_hit && rel == 12'h004 && indirect_index_bits <= 4'h8)
    else $error("indirect pulse without valid selection");
  a_ind_write: assert property (io_wr && io_hit && rel == 12'h004 &&
    indirect_index_bits <= 4'h8 |-> ind_wr)
    else $error("indirect write not passed on");
  a_ctx_gate: assert property (ctx_irq |-> ctx_switch_irq_status)
    else $error("interrupt without pending switch");
  a_index_upper: assert property (io_rd && io_hit && rel == 12'h003 |=> io_rdata[7:4] == 4'h0)
    else $error("index read shows reserved bits");
endmodule // ctrl_bank_monitor
bind control_device_register_bank ctrl_bank_monitor MON (.*);
`default_nettype wire

// >>> eeprom_model.sv
// serial configuration eeprom model on the peripheral data pin
`default_nettype none
module eeprom_model (
  input  wire logic clk,     // system clock, paces the idle pattern
  input  wire logic sclk,    // eeprom clock pin
  input  wire logic sclk_oe, // clock pin driven
  input  wire logic sdi,     // data pin from the bank
  input  wire logic sdi_oe,  // data pin driven
  output var  logic sdo      // serial output
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // shift-out of fixed contents, msb first
  // ****************************************************************
  localparam logic [7:0] ROM = 8'hA5; // contents shifted out
  logic [2:0] ptr  = 3'h7;             // next bit
  logic       idle = 1'b0;             // pattern while undriven
  // clock only counts while the bank drives it
  always @(posedge sclk) if (sclk_oe) ptr <= ptr - 3'h1;
  // toggle so a stale level never reads as data
  always @(posedge clk) idle <= ~idle;
  assign sdo = (sclk_oe && sdi_oe && sdi) ? ROM[ptr] : idle;
endmodule // eeprom_model
`default_nettype wire

// >>> control_device_register_bank_tb.sv
// self-checking bench for the control device register bank
`default_nettype none
module control_device_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // stimulus, design and eeprom model
  // ****************************************************************
  logic clk = 0, srst = 1, io_rd = 0, io_wr = 0, cfg_load = 0;
  logic ram_download_start = 0, ctx_switch = 0, ctx_is_native = 0;
  logic ctx_irq_ack = 0, iface_access = 0, modem_irq_pin = 0;
  logic synth_irq_pin = 0, cdrom_irq_pin = 0;
  logic [15:0] host_addr = 16'h0000;
  logic [11:0] control_io_base = 12'h120;
  logic [7:0] io_wdata = 0, ind_rdata = 8'h3C, ram_rdata = 0, v;
  logic [7:0] global_status_in = 0;
  logic [2:0] cfg_polarity = 3'h7;
  int n_errors = 0, compares = 0;
  wire logic [7:0] io_rdata, indirect_data_bits;
  wire logic [3:0] indirect_index_bits;
  wire logic [1:0] joystick_speed_sel, loopback_mux_sel;
  wire logic io_hit, ind_wr, ind_rd, ram_cmd_wr, ram_cmd_rd, ram_download_mode;
  wire logic eeprom_clk_o, eeprom_clk_oe, eeprom_dout_o, eeprom_dout_oe;
  wire logic periph_data_pin0, modem_irq, synth_irq, cdrom_irq, ctx_irq;
  wire logic ctx_switch_irq_status, mixer_pd_eff, mixer_regs_reset;
  wire logic processor_idle, ifaces_pd, adc_pd, dac_pd, fm_pd, vref_pd;
  wire logic rate_converter_pd, volume_freeze, mono_bypass, chip_reset;
  wire logic chip_pd, calibrate;
  control_device_register_bank DUT (.*);
  eeprom_model EE (.clk(clk), .sclk(eeprom_clk_o), .sclk_oe(eeprom_clk_oe),
    .sdi(eeprom_dout_o), .sdi_oe(eeprom_dout_oe), .sdo(periph_data_pin0));
  initial forever #50 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] o, input logic [7:0] d);
    @(posedge clk);
    host_addr <= {4'h0, control_io_base + 12'(o)};
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] o, output logic [7:0] d);
    @(posedge clk);
    host_addr <= {4'h0, control_io_base + 12'(o)};
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask
  task automatic hit(input logic [15:0] a, input logic e);
    @(posedge clk);
    host_addr <= a;
    #1 chk("io_hit", {7'h0, io_hit}, {7'h0, e});
  endtask
  task automatic t_reset();
    rd(3'h0, v); chk("off0", v, 8'h00);
    rd(3'h1, v); chk("off1", v & 8'hFB, 8'h80);
    rd(3'h2, v); chk("off2", v, 8'h00);
  endtask
  task automatic t_eeprom();
    wr(3'h1, 8'h06);
    repeat (4) @(posedge clk);
    rd(3'h1, v); chk("din", {7'h0, v[2]}, 8'h01);
    wr(3'h1, 8'h07);
    wr(3'h1, 8'h06);
    repeat (4) @(posedge clk);
    rd(3'h1, v); chk("din", {7'h0, v[2]}, 8'h00);
    wr(3'h1, 8'h03); chk("oe", {7'h0, eeprom_dout_oe}, 8'h00);
  endtask
  task automatic t_joy();
    for (int i = 0; i < 4; i++) begin
      wr(3'h0, 8'(i) | 8'h08); chk("speed", {6'h0, joystick_speed_sel}, 8'(i));
      rd(3'h0, v); chk("off0", v, 8'(i) | 8'h08);
      chk("idle", {7'h0, processor_idle}, 8'h01);
    end
    wr(3'h0, 8'h00);
  endtask
  task automatic t_decode();
    hit({4'h1, control_io_base}, 1'b0);
    hit({4'h0, control_io_base + 12'h008}, 1'b0);
    hit({4'h0, control_io_base + 12'h007}, 1'b1);
  endtask
  task automatic t_index();
    wr(3'h3, 8'hF3);
    rd(3'h3, v); chk("index", v, 8'h03);
    rd(3'h4, v); chk("data", v, 8'h3C);
    wr(3'h4, 8'h5A);
    wr(3'h3, 8'h09);
    wr(3'h4, 8'h11);
    rd(3'h3, v); chk("index", v, 8'h09);
  endtask
  task automatic t_gpd();
    wr(3'h2, 8'h80); chk("chip_pd", {7'h0, chip_pd}, 8'h01);
    hit({4'h0, control_io_base}, 1'b0);
    wr(3'h2, 8'h00); chk("chip_pd", {7'h0, chip_pd}, 8'h00);
    chk("cal", {7'h0, calibrate}, 8'h01);
  endtask
  task automatic t_pm();
    wr(3'h3, 8'h05);
    wr(3'h0, 8'h80);
    hit({4'h0, control_io_base + 12'h001}, 1'b0);
    wr(3'h0, 8'h00);
    rd(3'h1, v); chk("off1", v & 8'hFB, 8'h80);
    rd(3'h3, v); chk("index", v, 8'h00);
  endtask
  task automatic t_pol();
    wr(3'h1, 8'h20);
    @(posedge clk) modem_irq_pin <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("modem_irq", {7'h0, modem_irq}, 8'h01);
    wr(3'h1, 8'h00);
    repeat (8) @(posedge clk);
    #1 chk("modem_irq", {7'h0, modem_irq}, 8'h00);
  endtask
  task automatic t_pwr();
    wr(3'h1, 8'h08);
    chk("loop", {6'h0, loopback_mux_sel}, 8'h01);
    wr(3'h2, 8'h14);
    chk("dfb", {5'h0, dac_pd, fm_pd, mono_bypass}, 8'h07);
    wr(3'h2, 8'h68);
    chk("ref", {5'h0, vref_pd, rate_converter_pd, adc_pd}, 8'h07);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h44);
    chk("pm01", {5'h0, volume_freeze, adc_pd, mixer_pd_eff}, 8'h06);
    wr(3'h0, 8'h14);
    chk("mix", {6'h0, mixer_regs_reset, mixer_pd_eff}, 8'h03);
    chk("conv", {6'h0, adc_pd, dac_pd}, 8'h03);
    wr(3'h0, 8'hC0);
    chk("pm11", {6'h0, ifaces_pd, mixer_pd_eff}, 8'h03);
    @(posedge clk) iface_access <= 1'b1;
    @(posedge clk) iface_access <= 1'b0;
    #1 chk("wake", {6'h0, ifaces_pd, processor_idle}, 8'h00);
    rd(3'h0, v);
    chk("pm_rb", v, 8'hC0);
    @(posedge clk) cfg_load <= 1'b1;
    @(posedge clk) cfg_load <= 1'b0;
    rd(3'h1, v);
    chk("preset", v & 8'hE0, 8'hE0);
  endtask
  task automatic t_ctx();
    wr(3'h0, 8'h20);
    @(posedge clk) ctx_switch <= 1'b1;
    @(posedge clk) ctx_switch <= 1'b0;
    #1 chk("ctx_irq", {7'h0, ctx_irq}, 8'h01);
    rd(3'h7, v);
    chk("status", v, 8'h40);
    wr(3'h0, 8'h00);
    chk("noirq", {7'h0, ctx_irq}, 8'h00);
    @(posedge clk) ctx_irq_ack <= 1'b1;
    @(posedge clk) ctx_irq_ack <= 1'b0;
    #1 chk("ack", {7'h0, ctx_switch_irq_status}, 8'h00);
    @(posedge clk) ram_download_start <= 1'b1;
    @(posedge clk) ram_download_start <= 1'b0;
    #1 chk("dl", {7'h0, ram_download_mode}, 8'h01);
    wr(3'h6, 8'h00);
    chk("ram_end", {7'h0, ram_download_mode}, 8'h00);
  endtask
  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence after twenty cycles of reset
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset(); t_eeprom(); t_joy(); t_decode();
    t_index(); t_gpd(); t_pm(); t_pol(); t_pwr(); t_ctx();
    results();
  end
  // watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    #3000000;
    n_errors++;
    results();
  end
endmodule // control_device_register_bank_tb
`default_nettype wire
